// ===== core/bus_parity_master.sv
`timescale 1ns/1ns
module bus_parity_master (
	input wire logic ref_clk,
	input wire logic reset,
	par_bus_if.host bus,
	input wire logic start,
	input wire logic [3:0] startCommand,
	input wire logic [31:0] startAddr,
	input wire logic [31:0] startData,
	input wire logic [3:0] startByteEnable_n,
	input wire logic parityRespEnable,
	input wire logic clearStatus,
	output logic busy,
	output logic done,
	output logic [31:0] readData,
	output logic [15:0] statusWord,
	output logic systemErrorSeen
);

	typedef enum {H_IDLE, H_ADDR, H_TURN, H_DATA, H_GAP} hstate_e;

	hstate_e state;
	logic curRead;
	logic [31:0] dataHold;
	logic [3:0] beHold;
	logic [2:0] gapCount;
	logic sampledParity;
	logic chkRead;
	logic wrQ1;
	logic wrQ2;
	logic perrSlot;
	logic serrPrevHigh;

	wire [35:0] busWord = {bus.addr_data_bus, bus.cmd_byte_enable_n};
	wire busParity = ^busWord;
	wire xfer = ~bus.hostIrdy_n & bus.hostIrdyOe & ~bus.target_ready_n;
	wire parityMiss = sampledParity != bus.parity_bit;
	wire readErr = chkRead & parityMiss;
	wire writeErrSeen = wrQ2 & ~bus.data_parity_err_n;
	wire setDataParity = parityRespEnable & (readErr | writeErrSeen);
	wire setDetected = readErr;

	assign busy = state != H_IDLE;

	// ****************************************************************
	// transaction sequencer
	// ****************************************************************
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			state <= H_IDLE;
			curRead <= 1'b0;
			dataHold <= 32'h0;
			beHold <= 4'hF;
			gapCount <= 3'h0;
			done <= 1'b0;
			readData <= 32'h0;
			bus.hostAd <= 32'h0;
			bus.hostAdOe <= 1'b0;
			bus.hostCbe_n <= 4'hF;
			bus.hostCbeOe <= 1'b0;
			bus.hostFrame_n <= 1'b1;
			bus.hostFrameOe <= 1'b0;
			bus.hostIrdy_n <= 1'b1;
			bus.hostIrdyOe <= 1'b0;
		end else begin
			done <= 1'b0;
			case (state)
				H_IDLE: begin
					if (start) begin
						curRead <= ~startCommand[bus_parity_pkg::CMD_WRITE_BIT];
						dataHold <= startData;
						beHold <= startByteEnable_n;
						bus.hostAd <= startAddr;
						bus.hostAdOe <= 1'b1;
						bus.hostCbe_n <= startCommand;
						bus.hostCbeOe <= 1'b1;
						bus.hostFrame_n <= 1'b0;
						bus.hostFrameOe <= 1'b1;
						bus.hostIrdyOe <= 1'b1;
						state <= H_ADDR;
					end
				end
				H_ADDR: begin
					// unused byte lanes still carry stable values
					bus.hostCbe_n <= beHold;
					bus.hostFrame_n <= 1'b1;
					bus.hostIrdy_n <= 1'b0;
					bus.hostAd <= dataHold;
					bus.hostAdOe <= ~curRead;
					state <= curRead ? H_TURN : H_DATA;
				end
				H_TURN: begin
					state <= H_DATA;
				end
				H_DATA: begin
					// completes even after an error was flagged
					if (xfer) begin
						if (curRead) begin
							readData <= bus.addr_data_bus;
						end
						bus.hostAdOe <= 1'b0;
						bus.hostIrdy_n <= 1'b1;
						done <= 1'b1;
						gapCount <= bus_parity_pkg::MASTER_GAP_CLOCKS;
						state <= H_GAP;
					end
				end
				H_GAP: begin
					bus.hostCbeOe <= 1'b0;
					bus.hostFrameOe <= 1'b0;
					bus.hostIrdyOe <= 1'b0;
					gapCount <= gapCount - 3'h1;
					if (gapCount == 3'h1) begin
						state <= H_IDLE;
					end
				end
				default: state <= H_IDLE;
			endcase
		end
	end

	// ****************************************************************
	// parity generation, one clock behind address/data
	// ****************************************************************
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			bus.hostPar <= 1'b0;
			bus.hostParOe <= 1'b0;
		end else begin
			bus.hostPar <= busParity;
			bus.hostParOe <= bus.hostAdOe;
		end
	end

	// ****************************************************************
	// read data checking and error line
	// ****************************************************************
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			sampledParity <= 1'b0;
			chkRead <= 1'b0;
			wrQ1 <= 1'b0;
			wrQ2 <= 1'b0;
			perrSlot <= 1'b0;
			bus.hostPerr_n <= 1'b1;
			bus.hostPerrOe <= 1'b0;
		end else begin
			sampledParity <= busParity;
			// only the master reports read data errors
			chkRead <= xfer & curRead;
			wrQ1 <= xfer & ~curRead;
			wrQ2 <= wrQ1;
			perrSlot <= chkRead;
			bus.hostPerrOe <= chkRead | perrSlot;
			bus.hostPerr_n <= ~(readErr & parityRespEnable);
		end
	end

	// ****************************************************************
	// status: set wins over clear
	// ****************************************************************
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			statusWord <= bus_parity_pkg::STATUS_RESET;
		end else begin
			// master samples the error line during writes
			statusWord[bus_parity_pkg::STATUS_DATA_PARITY_BIT] <=
				setDataParity |
				(statusWord[bus_parity_pkg::STATUS_DATA_PARITY_BIT] &
				~clearStatus);
			statusWord[bus_parity_pkg::STATUS_DETECTED_PARITY_BIT] <=
				setDetected |
				(statusWord[bus_parity_pkg::STATUS_DETECTED_PARITY_BIT] &
				~clearStatus);
		end
	end

	// ****************************************************************
	// system error observer
	// ****************************************************************
	// wired-OR line may bounce, so trust negation only twice in a row
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			serrPrevHigh <= 1'b0;
			systemErrorSeen <= 1'b0;
		end else begin
			serrPrevHigh <= bus.system_err_n;
			if (!bus.system_err_n) begin
				systemErrorSeen <= 1'b1;
			end else if (serrPrevHigh) begin
				systemErrorSeen <= 1'b0;
			end
		end
	end

endmodule

// ===== core/bus_parity_pkg.sv
package bus_parity_pkg;

	// ****************************************************************
	// bus widths
	// ****************************************************************
	localparam int AD_WIDTH = 32;
	localparam int CBE_WIDTH = 4;

	// ****************************************************************
	// command codes on the command/byte-enable lines
	// ****************************************************************
	localparam logic [3:0] CMD_SPECIAL = 4'h1;
	localparam logic [3:0] CMD_MEM_READ = 4'h6;
	localparam logic [3:0] CMD_MEM_WRITE = 4'h7;
	// odd command codes move data from master to target
	localparam int CMD_WRITE_BIT = 0;

	// ****************************************************************
	// timing in bus clocks
	// ****************************************************************
	// error line is driven this many clocks after the data transfer
	localparam int PERR_LAG_CLOCKS = 2;
	// negated samples needed before the system error line is trusted
	localparam int SERR_QUIET_SAMPLES = 2;
	// master idle clocks after a transfer, covers the error line tail
	localparam logic [2:0] MASTER_GAP_CLOCKS = 3'h4;

	// ****************************************************************
	// master status word
	// ****************************************************************
	localparam int STATUS_DATA_PARITY_BIT = 8;
	localparam int STATUS_DETECTED_PARITY_BIT = 15;
	localparam logic [15:0] STATUS_RESET = 16'h0000;

endpackage

// ===== core/bus_parity_target.sv
`timescale 1ns/1ns
module bus_parity_target (
	input wire logic ref_clk,
	input wire logic reset,
	par_bus_if.device bus,
	input wire logic parityRespEnable,
	input wire logic sysErrEnable,
	input wire logic [31:0] readDataIn,
	input wire logic clearStatus,
	output logic [31:0] writeData,
	output logic [3:0] writeByteEnable_n,
	output logic writeStrobe,
	output logic specialStrobe,
	output logic detectedParityError,
	output logic signaledSystemError
);

	typedef enum {T_IDLE, T_TURN, T_DATA, T_DONE} tstate_e;

	tstate_e state;
	logic curRead;
	logic curSpecial;
	logic sampledParity;
	logic chkAddr;
	logic chkWrite;
	logic chkSpecial;
	logic perrSlot;

	// ****************************************************************
	// bus decode
	// ****************************************************************
	wire [35:0] busWord = {bus.addr_data_bus, bus.cmd_byte_enable_n};
	wire busParity = ^busWord;
	wire addrSeen = ~bus.cycleFrame_n & (state == T_IDLE);
	wire cmdRead = ~bus.cmd_byte_enable_n[bus_parity_pkg::CMD_WRITE_BIT];
	wire cmdSpecial = bus.cmd_byte_enable_n == bus_parity_pkg::CMD_SPECIAL;
	wire xfer = ~bus.initiator_ready_n & ~bus.devTrdy_n & bus.devTrdyOe;
	wire parityMiss = sampledParity != bus.parity_bit;
	wire addrErr = chkAddr & parityMiss;
	wire writeErr = chkWrite & parityMiss;
	wire specialErr = chkSpecial & parityMiss;
	wire anyErr = addrErr | writeErr | specialErr;
	// system line needs both enables
	wire serrFire = (addrErr | specialErr) & sysErrEnable &
		parityRespEnable;

	// ****************************************************************
	// target sequencer
	// ****************************************************************
	// always completes; no target termination on parity errors
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			state <= T_IDLE;
			curRead <= 1'b0;
			curSpecial <= 1'b0;
			writeData <= 32'h0;
			writeByteEnable_n <= 4'hF;
			writeStrobe <= 1'b0;
			specialStrobe <= 1'b0;
			bus.devAd <= 32'h0;
			bus.devAdOe <= 1'b0;
			bus.devTrdy_n <= 1'b1;
			bus.devTrdyOe <= 1'b0;
		end else begin
			writeStrobe <= 1'b0;
			specialStrobe <= 1'b0;
			case (state)
				T_IDLE: begin
					if (addrSeen) begin
						curRead <= cmdRead;
						curSpecial <= cmdSpecial;
						bus.devTrdyOe <= 1'b1;
						bus.devTrdy_n <= cmdRead;
						state <= cmdRead ? T_TURN : T_DATA;
					end
				end
				T_TURN: begin
					// whole word driven, unused lanes stay stable
					bus.devAd <= readDataIn;
					bus.devAdOe <= 1'b1;
					bus.devTrdy_n <= 1'b0;
					state <= T_DATA;
				end
				T_DATA: begin
					if (xfer) begin
						// data kept even on a parity error
						if (!curRead) begin
							writeData <= bus.addr_data_bus;
							writeByteEnable_n <= bus.cmd_byte_enable_n;
							writeStrobe <= ~curSpecial;
							specialStrobe <= curSpecial;
						end
						bus.devAdOe <= 1'b0;
						bus.devTrdy_n <= 1'b1;
						state <= T_DONE;
					end
				end
				T_DONE: begin
					bus.devTrdyOe <= 1'b0;
					state <= T_IDLE;
				end
				default: state <= T_IDLE;
			endcase
		end
	end

	// ****************************************************************
	// parity generation
	// ****************************************************************
	// same equation for every command, read data included
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			bus.devPar <= 1'b0;
			bus.devParOe <= 1'b0;
		end else begin
			bus.devPar <= busParity;
			bus.devParOe <= bus.devAdOe;
		end
	end

	// ****************************************************************
	// parity checking
	// ****************************************************************
	// only the target checks the address; the master covers unused
	// address lines, which lands them in this parity too
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			sampledParity <= 1'b0;
			chkAddr <= 1'b0;
			chkWrite <= 1'b0;
			chkSpecial <= 1'b0;
		end else begin
			sampledParity <= busParity;
			chkAddr <= addrSeen;
			// only the selected target checks write data
			chkWrite <= xfer & ~curRead & ~curSpecial;
			chkSpecial <= xfer & ~curRead & curSpecial;
		end
	end

	// ****************************************************************
	// data parity error line
	// ****************************************************************
	// one slot per transfer, never read back by the target
	// slot lands two clocks after transfer, earliest third after address
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			perrSlot <= 1'b0;
			bus.devPerr_n <= 1'b1;
			bus.devPerrOe <= 1'b0;
		end else begin
			perrSlot <= chkWrite;
			bus.devPerrOe <= chkWrite | perrSlot;
			bus.devPerr_n <= ~(writeErr & parityRespEnable);
		end
	end
	// early assertion is not used, so the hold window is trivially met

	// ****************************************************************
	// system error line and status
	// ****************************************************************
	// no data-parity-reported bit exists on this end
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			bus.devSerrOe <= 1'b0;
			detectedParityError <= 1'b0;
			signaledSystemError <= 1'b0;
		end else begin
			bus.devSerrOe <= serrFire;
			detectedParityError <= anyErr |
				(detectedParityError & ~clearStatus);
			signaledSystemError <= serrFire |
				(signaledSystemError & ~clearStatus);
		end
	end

endmodule

// ===== core/par_bus_if.sv
`timescale 1ns/1ns
interface par_bus_if;

	// ****************************************************************
	// drive requests from each end
	// ****************************************************************
	logic [31:0] devAd;
	logic devAdOe;
	logic devPar;
	logic devParOe;
	logic devPerr_n;
	logic devPerrOe;
	logic devSerrOe;
	logic devTrdy_n;
	logic devTrdyOe;
	logic [31:0] hostAd;
	logic hostAdOe;
	logic [3:0] hostCbe_n;
	logic hostCbeOe;
	logic hostPar;
	logic hostParOe;
	logic hostPerr_n;
	logic hostPerrOe;
	logic hostFrame_n;
	logic hostFrameOe;
	logic hostIrdy_n;
	logic hostIrdyOe;

	// ****************************************************************
	// resolved wire levels, undriven lines float high
	// ****************************************************************
	logic [31:0] addr_data_bus;
	logic [3:0] cmd_byte_enable_n;
	logic parity_bit;
	logic data_parity_err_n;
	logic system_err_n;
	logic cycleFrame_n;
	logic initiator_ready_n;
	logic target_ready_n;

	assign addr_data_bus = devAdOe ? devAd : (hostAdOe ? hostAd : '1);
	assign cmd_byte_enable_n = hostCbeOe ? hostCbe_n : 4'hF;
	assign parity_bit = devParOe ? devPar : (hostParOe ? hostPar : 1'b1);
	assign data_parity_err_n = devPerrOe ? devPerr_n :
		(hostPerrOe ? hostPerr_n : 1'b1);
	// open drain: any enable pulls low
	assign system_err_n = ~devSerrOe;
	assign cycleFrame_n = hostFrameOe ? hostFrame_n : 1'b1;
	assign initiator_ready_n = hostIrdyOe ? hostIrdy_n : 1'b1;
	assign target_ready_n = devTrdyOe ? devTrdy_n : 1'b1;

	modport device (
		input addr_data_bus,
		input cmd_byte_enable_n,
		input parity_bit,
		input cycleFrame_n,
		input initiator_ready_n,
		output devAd,
		output devAdOe,
		output devPar,
		output devParOe,
		output devPerr_n,
		output devPerrOe,
		output devSerrOe,
		output devTrdy_n,
		output devTrdyOe
	);

	modport host (
		input addr_data_bus,
		input cmd_byte_enable_n,
		input parity_bit,
		input data_parity_err_n,
		input system_err_n,
		input target_ready_n,
		output hostAd,
		output hostAdOe,
		output hostCbe_n,
		output hostCbeOe,
		output hostPar,
		output hostParOe,
		output hostPerr_n,
		output hostPerrOe,
		output hostFrame_n,
		output hostFrameOe,
		output hostIrdy_n,
		output hostIrdyOe
	);

endinterface

// ===== test/bus_parity_monitor.sv
`timescale 1ns/1ns
module bus_parity_monitor (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic [31:0] addr_data_bus,
	input wire logic [3:0] cmd_byte_enable_n,
	input wire logic parity_bit,
	input wire logic devAdOe,
	input wire logic hostAdOe,
	input wire logic devParOe,
	input wire logic hostParOe,
	input wire logic devPerr_n,
	input wire logic devPerrOe,
	input wire logic hostPerr_n,
	input wire logic hostPerrOe,
	input wire logic data_parity_err_n,
	input wire logic system_err_n,
	input wire logic cycleFrame_n,
	input wire logic initiator_ready_n,
	input wire logic target_ready_n
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (reset);

	logic xfer;
	logic special;
	assign xfer = !initiator_ready_n && !target_ready_n;
	// special cycles report on the system line, so no error line tail
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset)
			special <= 1'b0;
		else if (!cycleFrame_n)
			special <= cmd_byte_enable_n == bus_parity_pkg::CMD_SPECIAL;
	end

	property p_par_value;
		(devAdOe || hostAdOe) |=> parity_bit ==
			^{$past(addr_data_bus), $past(cmd_byte_enable_n)};
	endproperty
	a_par_value: assert property (p_par_value)
		else $error("parity bit does not give even ones count");
	property p_par_owner;
		(devAdOe |=> devParOe) and (hostAdOe |=> hostParOe);
	endproperty
	a_par_owner: assert property (p_par_owner)
		else $error("parity not driven by the data driver");
	property p_par_lag;
		(devParOe |-> $past(devAdOe)) and (hostParOe |-> $past(hostAdOe));
	endproperty
	a_par_lag: assert property (p_par_lag)
		else $error("parity driven without data one clock before");
	property p_perr_early;
		$fell(cycleFrame_n) |-> (!devPerrOe && !hostPerrOe) [*3];
	endproperty
	a_perr_early: assert property (p_perr_early)
		else $error("error line driven too soon after address");
	property p_perr_write;
		xfer && hostAdOe && !special |-> ##2 devPerrOe && !hostPerrOe;
	endproperty
	a_perr_write: assert property (p_perr_write)
		else $error("target error line missing after write");
	property p_perr_read;
		xfer && devAdOe |-> ##2 hostPerrOe && !devPerrOe;
	endproperty
	a_perr_read: assert property (p_perr_read)
		else $error("master error line missing after read");
	property p_tail_dev;
		$rose(devPerrOe) |=> devPerrOe && devPerr_n ##1 !devPerrOe;
	endproperty
	a_tail_dev: assert property (p_tail_dev)
		else $error("target error line not driven high then released");
	property p_tail_host;
		$rose(hostPerrOe) |=> hostPerrOe && hostPerr_n ##1 !hostPerrOe;
	endproperty
	a_tail_host: assert property (p_tail_host)
		else $error("master error line not driven high then released");
	property p_special_quiet;
		special && xfer |-> ##2 !devPerrOe;
	endproperty
	a_special_quiet: assert property (p_special_quiet)
		else $error("special cycle used the data error line");
	property p_clean;
		data_parity_err_n && system_err_n;
	endproperty
	a_clean: assert property (p_clean)
		else $error("error reported on a clean bus");
endmodule

// ===== test/testbench.sv
`timescale 1ns/1ns
module testbench;
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	logic start = 1'b0;
	logic [3:0] startCommand = 4'h0;
	logic [31:0] startAddr = 32'h0;
	logic [31:0] startData = 32'h0;
	logic [3:0] startByteEnable_n = 4'h0;
	logic clrA = 1'b0;
	logic [31:0] readDataIn = 32'h0;
	logic respB = 1'b0;
	logic serrB = 1'b0;
	logic clrB = 1'b0;
	logic start2 = 1'b0;
	logic busy2, systemErrorSeen2;
	logic [31:0] readData2;
	logic [15:0] statusWord2;
	logic busy, done, systemErrorSeen, writeStrobe, specialStrobe;
	logic detA, sigA, detB, sigB;
	logic [31:0] readData, writeData, writeDataB;
	logic [15:0] statusWord;
	logic [3:0] writeByteEnable_n;
	logic [7:0] perrLog, serrLog;
	logic [31:0] pats [3] = '{32'hFFFFFFFF, 32'h00000000, 32'hA5A55A5A};
	logic [3:0] bes [3] = '{4'h0, 4'hF, 4'h5};
	int failures = 0;
	int samples_checked = 0;
	int writeCount = 0;
	int specialCount = 0;

	always #20 ref_clk = ~ref_clk;

	par_bus_if par_bus_if_i ();
	// second bus: bench stands in for a master that corrupts parity
	par_bus_if par_bus_if_i2 ();
	// third bus: bench stands in for a target that corrupts read parity
	par_bus_if par_bus_if_i3 ();

	bus_parity_master bus_parity_master_i (.ref_clk(ref_clk),
		.reset(reset), .bus(par_bus_if_i.host), .start(start),
		.startCommand(startCommand), .startAddr(startAddr),
		.startData(startData), .startByteEnable_n(startByteEnable_n),
		.parityRespEnable(1'b1), .clearStatus(clrA), .busy(busy),
		.done(done), .readData(readData), .statusWord(statusWord),
		.systemErrorSeen(systemErrorSeen));
	bus_parity_target bus_parity_target_i (.ref_clk(ref_clk),
		.reset(reset), .bus(par_bus_if_i.device), .parityRespEnable(1'b1),
		.sysErrEnable(1'b1), .readDataIn(readDataIn), .clearStatus(clrA),
		.writeData(writeData), .writeByteEnable_n(writeByteEnable_n),
		.writeStrobe(writeStrobe), .specialStrobe(specialStrobe),
		.detectedParityError(detA), .signaledSystemError(sigA));
	bus_parity_target bus_parity_target_i2 (.ref_clk(ref_clk),
		.reset(reset), .bus(par_bus_if_i2.device), .parityRespEnable(respB),
		.sysErrEnable(serrB), .readDataIn(32'h0), .clearStatus(clrB),
		.writeData(writeDataB), .writeByteEnable_n(), .writeStrobe(),
		.specialStrobe(), .detectedParityError(detB),
		.signaledSystemError(sigB));
	bus_parity_master bus_parity_master_i2 (.ref_clk(ref_clk),
		.reset(reset), .bus(par_bus_if_i3.host), .start(start2),
		.startCommand(startCommand), .startAddr(startAddr),
		.startData(startData), .startByteEnable_n(startByteEnable_n),
		.parityRespEnable(respB), .clearStatus(clrB), .busy(busy2),
		.done(), .readData(readData2), .statusWord(statusWord2),
		.systemErrorSeen(systemErrorSeen2));
	bus_parity_monitor bus_parity_monitor_i (.ref_clk(ref_clk),
		.reset(reset), .addr_data_bus(par_bus_if_i.addr_data_bus),
		.cmd_byte_enable_n(par_bus_if_i.cmd_byte_enable_n),
		.parity_bit(par_bus_if_i.parity_bit),
		.devAdOe(par_bus_if_i.devAdOe), .hostAdOe(par_bus_if_i.hostAdOe),
		.devParOe(par_bus_if_i.devParOe),
		.hostParOe(par_bus_if_i.hostParOe),
		.devPerr_n(par_bus_if_i.devPerr_n),
		.devPerrOe(par_bus_if_i.devPerrOe),
		.hostPerr_n(par_bus_if_i.hostPerr_n),
		.hostPerrOe(par_bus_if_i.hostPerrOe),
		.data_parity_err_n(par_bus_if_i.data_parity_err_n),
		.system_err_n(par_bus_if_i.system_err_n),
		.cycleFrame_n(par_bus_if_i.cycleFrame_n),
		.initiator_ready_n(par_bus_if_i.initiator_ready_n),
		.target_ready_n(par_bus_if_i.target_ready_n));

	// pulses stand one cycle, so one falling-edge sample each
	always @(negedge ref_clk) begin
		if (writeStrobe === 1'b1)
			writeCount++;
		if (specialStrobe === 1'b1)
			specialCount++;
	end

	// ****************************************************************
	// tasks
	// ****************************************************************
	task automatic print_verdict();
		if (failures == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic check_value(input logic [31:0] got,
		input logic [31:0] exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: %s got %h wanted %h", $time, what,
				got, exp);
		end
	endtask

	task automatic run_master(input logic [3:0] cmd,
		input logic [31:0] adr, input logic [31:0] dat, input logic [3:0] be);
		int k;
		startCommand = cmd;
		startAddr = adr;
		startData = dat;
		startByteEnable_n = be;
		start = 1'b1;
		@(negedge ref_clk);
		start = 1'b0;
		for (k = 0; k < 20 && done !== 1'b1; k++)
			@(negedge ref_clk);
		if (done !== 1'b1) begin
			failures++;
			print_verdict();
		end
		for (k = 0; k < 20 && busy !== 1'b0; k++)
			@(negedge ref_clk);
		if (busy !== 1'b0 || k == 0) begin
			failures++;
			print_verdict();
		end
	endtask

	// one write frame; logs hold each error line per cycle, bit k = cycle k
	task automatic run_fault(input logic [3:0] cmd, input logic [31:0] dat,
		input logic badA, input logic badD, input logic resp,
		input logic serrEn, input logic [7:0] expP, input logic [7:0] expS,
		input logic expDet, input logic expSig);
		int k;
		respB = resp;
		serrB = serrEn;
		perrLog = 8'hFF;
		serrLog = 8'hFF;
		for (k = 1; k < 8; k++) begin
			@(negedge ref_clk);
			perrLog[k] = par_bus_if_i2.data_parity_err_n;
			serrLog[k] = par_bus_if_i2.system_err_n;
			par_bus_if_i2.hostFrameOe = k < 4;
			par_bus_if_i2.hostFrame_n = k != 1;
			par_bus_if_i2.hostIrdyOe = k < 4;
			par_bus_if_i2.hostIrdy_n = k != 2;
			par_bus_if_i2.hostAdOe = k < 3;
			par_bus_if_i2.hostCbeOe = k < 3;
			par_bus_if_i2.hostAd = (k == 1) ? 32'h00002000 : dat;
			par_bus_if_i2.hostCbe_n = (k == 1) ? cmd : 4'h0;
			par_bus_if_i2.hostParOe = k == 2 || k == 3;
			par_bus_if_i2.hostPar = (k == 2) ? ^{32'h00002000, cmd} ^ badA
				: ^{dat, 4'h0} ^ badD;
		end
		check_value({24'h0, perrLog}, {24'h0, expP},
			"data error line");
		check_value({24'h0, serrLog}, {24'h0, expS},
			"system error line");
		check_value({30'h0, detB, sigB}, {30'h0, expDet, expSig},
			"sticky");
		if (!badA && !badD)
			check_value(writeDataB, dat, "clean write data");
		clrB = 1'b1;
		@(negedge ref_clk);
		clrB = 1'b0;
	endtask

	// master read answered by the bench; bad flips the parity bit
	task automatic run_read_fault(input logic bad, input logic resp,
		input logic [7:0] expP, input logic [15:0] expS);
		int k;
		respB = resp;
		perrLog = 8'hFF;
		startCommand = bus_parity_pkg::CMD_MEM_READ;
		startByteEnable_n = 4'h0;
		start2 = 1'b1;
		for (k = 1; k < 8; k++) begin
			@(negedge ref_clk);
			perrLog[k] = par_bus_if_i3.data_parity_err_n;
			start2 = 1'b0;
			par_bus_if_i3.devTrdyOe = k > 1 && k < 5;
			par_bus_if_i3.devTrdy_n = k != 3;
			par_bus_if_i3.devAdOe = k == 3;
			par_bus_if_i3.devParOe = k == 4;
			par_bus_if_i3.devPar = ^{32'hC3C3A5A5, 4'h0} ^ bad;
		end
		for (k = 0; k < 8 && busy2 !== 1'b0; k++)
			@(negedge ref_clk);
		check_value({24'h0, perrLog}, {24'h0, expP},
			"read error line");
		check_value({15'h0, busy2, statusWord2}, {16'h0, expS},
			"master status");
		check_value(readData2, 32'hC3C3A5A5, "read data kept");
		clrB = 1'b1;
		@(negedge ref_clk);
		clrB = 1'b0;
	endtask

	// ****************************************************************
	// sequence
	// ****************************************************************
	initial begin
		par_bus_if_i2.hostPerrOe = 1'b0;
		par_bus_if_i2.hostPerr_n = 1'b1;
		par_bus_if_i2.hostFrameOe = 1'b0;
		par_bus_if_i2.hostIrdyOe = 1'b0;
		par_bus_if_i2.hostAdOe = 1'b0;
		par_bus_if_i2.hostCbeOe = 1'b0;
		par_bus_if_i2.hostParOe = 1'b0;
		par_bus_if_i3.devAd = 32'hC3C3A5A5;
		par_bus_if_i3.devAdOe = 1'b0;
		par_bus_if_i3.devParOe = 1'b0;
		par_bus_if_i3.devPerrOe = 1'b0;
		par_bus_if_i3.devSerrOe = 1'b0;
		par_bus_if_i3.devTrdyOe = 1'b0;
		repeat (4) @(posedge ref_clk);
		@(negedge ref_clk);
		reset = 1'b0;
		check_value({16'h0, statusWord}, 32'h0, "status after reset");
		for (int i = 0; i < 3; i++) begin
			run_master(bus_parity_pkg::CMD_MEM_WRITE, 32'h1000 + i, pats[i],
				bes[i]);
			check_value(writeData, pats[i], "write data");
			check_value({28'h0, writeByteEnable_n}, {28'h0, bes[i]},
				"byte lanes");
			readDataIn = ~pats[i];
			run_master(bus_parity_pkg::CMD_MEM_READ, 32'h3000, 32'h0,
				bes[i]);
			check_value(readData, ~pats[i], "read data");
		end
		run_master(bus_parity_pkg::CMD_SPECIAL, 32'h0, 32'h000000A5,
			4'h0);
		check_value(writeCount, 3, "write strobes");
		check_value(specialCount, 1, "special strobes");
		check_value({13'h0, statusWord, detA, sigA, systemErrorSeen}, 32'h0,
			"clean status");
		run_fault(bus_parity_pkg::CMD_MEM_WRITE, 32'h12345678, 1'b0, 1'b1,
			1'b1, 1'b1, 8'hEF, 8'hFF, 1'b1, 1'b0);
		run_fault(bus_parity_pkg::CMD_MEM_WRITE, 32'h12345678, 1'b0, 1'b1,
			1'b0, 1'b1, 8'hFF, 8'hFF, 1'b1, 1'b0);
		run_fault(bus_parity_pkg::CMD_MEM_WRITE, 32'h0F0F0F0F, 1'b1, 1'b0,
			1'b1, 1'b1, 8'hFF, 8'hF7, 1'b1, 1'b1);
		run_fault(bus_parity_pkg::CMD_MEM_WRITE, 32'h0F0F0F0F, 1'b1, 1'b0,
			1'b1, 1'b0, 8'hFF, 8'hFF, 1'b1, 1'b0);
		run_fault(bus_parity_pkg::CMD_SPECIAL, 32'h000000A5, 1'b0, 1'b1,
			1'b1, 1'b1, 8'hFF, 8'hEF, 1'b1, 1'b1);
		run_fault(bus_parity_pkg::CMD_MEM_WRITE, 32'hCAFE0001, 1'b0, 1'b0,
			1'b1, 1'b1, 8'hFF, 8'hFF, 1'b0, 1'b0);
		run_read_fault(1'b1, 1'b1, 8'hDF, 16'h8100);
		run_read_fault(1'b1, 1'b0, 8'hFF, 16'h8000);
		// one negated sample is not enough to trust the wired line
		par_bus_if_i3.devSerrOe = 1'b1;
		@(negedge ref_clk);
		par_bus_if_i3.devSerrOe = 1'b0;
		@(negedge ref_clk);
		check_value(systemErrorSeen2, 1'b1, "one quiet sample");
		@(negedge ref_clk);
		check_value(systemErrorSeen2, 1'b0, "two quiet samples");
		print_verdict();
	end
endmodule
